// ===== common/bpm_pkg.sv
// ****************************************************************
// pin multiplexer constants
// ****************************************************************
package bpm_pkg;

    typedef enum logic [3:0] {
        MODE_UART = 4'h0,
        MODE_SYNC_FIFO = 4'h1,
        MODE_ASYNC_FIFO = 4'h2,
        MODE_ASYNC_BB = 4'h3,
        MODE_SYNC_BB = 4'h4,
        MODE_ENGINE = 4'h5,
        MODE_FAST_SER = 4'h6,
        MODE_CPU_FIFO = 4'h7,
        MODE_HALF_DUPLEX = 4'h8
    } bpm_mode_type;

    localparam int A_W = 8;
    localparam int C_W = 10;
    localparam int GP_W = 14;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CFG_W = 9;
    localparam int MODE_W = 4;

    localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_LOAD = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

    localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_LINE_DRV = 4;
    localparam int CFG_RX_LED = 5;
    localparam int CFG_TX_LED = 6;
    localparam int CFG_PWR_SAVE = 7;
    localparam int CFG_REMOTE_WAKE = 8;

    localparam int ST_MODE_LSB = 0;
    localparam int ST_LOADED = 4;
    localparam int ST_SUSPEND = 5;
    localparam int ST_RESUME = 6;
    localparam int ST_MEM = 7;

    localparam int PC_PWR_SAVE = 7;
    // nominal weak pull strength in kilo-ohm, for reference only
    localparam int PULL_KOHM = 75;
    localparam logic [A_W-1:0] UART_A_DRIVE = 8'h15;

endpackage : bpm_pkg

// ===== common/bpm_cfg_if.sv
// ****************************************************************
// configuration hand-off between register file and mode control
// ****************************************************************
interface bpm_cfg_if;
    import bpm_pkg::*;
    logic memPresent;
    logic cfgDone;
    bpm_mode_type cfgMode;
    bpm_mode_type activeMode;
    logic loaded;

    modport ctrl (
        input memPresent,
        input cfgDone,
        input cfgMode,
        output activeMode,
        output loaded
    );

    modport top (
        output memPresent,
        output cfgDone,
        output cfgMode,
        input activeMode,
        input loaded
    );
endinterface : bpm_cfg_if

// ===== rtl/bpm_sync3.sv
// ****************************************************************
// three-stage pin synchroniser with agreement filter
// ****************************************************************
module bpm_sync3 #(
    parameter int WIDTH = 1
) (
    input logic clk,
    input logic resetn,
    input logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_d;

    // a bit only moves once stages two and three agree
    always_comb begin
        out_d = (s2_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
    end

    // idle level is high: undriven lines sit on their pull-ups
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            out_q <= '1;
        end else begin
            s1_q <= asyncIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign syncOut = out_q;

    a_sync_agree: assert property (@(posedge clk) disable iff (!resetn)
        (s2_q == s3_q) |=> (out_q == $past(s2_q)))
        else $error("synchroniser output ignored agreeing stages");

endmodule : bpm_sync3

// ===== rtl/bpm_mode_ctrl.sv
// ****************************************************************
// start-up mode sequencing
// ****************************************************************
module bpm_mode_ctrl (
    input logic clk,
    input logic resetn,
    bpm_cfg_if.ctrl cfg
);
    import bpm_pkg::*;

    typedef enum logic [1:0] {
        ST_BOOT = 2'b01,
        ST_RUN = 2'b10
    } bpm_boot_type;

    bpm_boot_type state_q;
    bpm_boot_type state_d;
    bpm_mode_type mode_q;
    bpm_mode_type mode_d;

    // without memory the boot state never ends, so uart stays
    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        case (state_q)
            ST_BOOT: begin
                if (cfg.memPresent && cfg.cfgDone) begin
                    state_d = ST_RUN;
                    mode_d = cfg.cfgMode;
                end
            end
            ST_RUN: begin
                if (cfg.memPresent && cfg.cfgDone) begin
                    mode_d = cfg.cfgMode;
                end
            end
            default: begin
                state_d = ST_BOOT;
                mode_d = MODE_UART;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= ST_BOOT;
            mode_q <= MODE_UART;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
        end
    end

    assign cfg.activeMode = mode_q;
    assign cfg.loaded = (state_q == ST_RUN);

    a_boot_uart: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_BOOT) |-> (mode_q == MODE_UART))
        else $error("mode left uart before configuration load");

    a_no_mem_stay: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_BOOT && !cfg.memPresent) |=> (state_q == ST_BOOT))
        else $error("boot state left without configuration memory");

    a_load_switch: assert property (@(posedge clk) disable iff (!resetn)
        (cfg.memPresent && cfg.cfgDone)
        |=> (mode_q == $past(cfg.cfgMode)) && (state_q == ST_RUN))
        else $error("configured mode not taken on load");

endmodule : bpm_mode_ctrl

// ===== rtl/bpm_pin_mux.sv
// The implementer's own choices: the plain strobed port and the address map.
module bpm_pin_mux (
    input logic clk,
    input logic resetn,
    input logic [bpm_pkg::A_W-1:0] portAIn,
    output logic [bpm_pkg::A_W-1:0] portAOut,
    output logic [bpm_pkg::A_W-1:0] portAOe,
    output logic [bpm_pkg::A_W-1:0] portAPullUp,
    input logic [bpm_pkg::C_W-1:0] portCIn,
    output logic [bpm_pkg::C_W-1:0] portCOut,
    output logic [bpm_pkg::C_W-1:0] portCOe,
    output logic [bpm_pkg::C_W-1:0] portCPullUp,
    output logic [bpm_pkg::C_W-1:0] portCPullDown,
    input logic cfgMemPresent,
    input logic [bpm_pkg::ADDR_W-1:0] regAddr,
    input logic [bpm_pkg::DATA_W-1:0] regWdata,
    input logic regWr,
    input logic regRd,
    output logic [bpm_pkg::DATA_W-1:0] regRdata,
    input logic uartTx,
    input logic uartRtsN,
    input logic uartDtrN,
    input logic lineDrvEn,
    input logic rxLedN,
    input logic txLedN,
    input logic [bpm_pkg::A_W-1:0] dataOut,
    input logic dataOe,
    input logic rxAvailN,
    input logic txSpaceN,
    input logic fifoClk,
    input logic bbWrN,
    input logic bbRdN,
    input logic serClk,
    input logic serOut,
    input logic serSel,
    input logic [bpm_pkg::GP_W-1:0] gpOut,
    input logic [bpm_pkg::GP_W-1:0] gpOe,
    input logic fsDataOut,
    input logic fast_ser_clear,
    input logic hdStatus,
    output logic [bpm_pkg::A_W-1:0] dataIn,
    output logic [bpm_pkg::GP_W-1:0] gpIn,
    output logic [7:0] ctlIn,
    output logic suspend,
    output logic resumeReq
);
    import bpm_pkg::*;

    // ****************************************************************
    // pin synchronisers and mode control
    // ****************************************************************
    localparam int SYNC_W = A_W + C_W + 1;
    logic [SYNC_W-1:0] syncAll;
    logic [A_W-1:0] pa;
    logic [C_W-1:0] pc;
    logic memSync;

    bpm_sync3 #(.WIDTH(SYNC_W)) uSync (
        .clk(clk),
        .resetn(resetn),
        .asyncIn({cfgMemPresent, portCIn, portAIn}),
        .syncOut(syncAll)
    );
    assign pa = syncAll[A_W-1:0];
    assign pc = syncAll[A_W+C_W-1:A_W];
    assign memSync = syncAll[SYNC_W-1];

    bpm_cfg_if cfgIf ();
    bpm_mode_ctrl uModeCtrl (
        .clk(clk),
        .resetn(resetn),
        .cfg(cfgIf)
    );

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [CFG_W-1:0] cfgReg_q;
    logic [CFG_W-1:0] cfgReg_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] status;
    bpm_mode_type mode;
    logic loaded;
    logic suspend_q;
    logic resume_q;

    assign mode = cfgIf.activeMode;
    assign loaded = cfgIf.loaded;
    assign cfgIf.memPresent = memSync;
    assign cfgIf.cfgDone = regWr && (regAddr == OFS_LOAD);
    assign cfgIf.cfgMode = bpm_mode_type'(cfgReg_q[CFG_MODE_LSB +: MODE_W]);

    always_comb begin
        status = '0;
        status[ST_MODE_LSB +: MODE_W] = mode;
        status[ST_LOADED] = loaded;
        status[ST_SUSPEND] = suspend_q;
        status[ST_RESUME] = resume_q;
        status[ST_MEM] = memSync;
        cfgReg_d = cfgReg_q;
        rdata_d = '0;
        if (regWr && regAddr == OFS_CONFIG) begin
            cfgReg_d = regWdata[CFG_W-1:0];
        end
        if (regRd) begin
            case (regAddr)
                OFS_CONFIG: rdata_d = {{(DATA_W-CFG_W){1'b0}}, cfgReg_q};
                OFS_STATUS: rdata_d = status;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cfgReg_q <= CFG_RESET;
            rdata_q <= '0;
        end else begin
            cfgReg_q <= cfgReg_d;
            rdata_q <= rdata_d;
        end
    end

    // options stay off until the memory contents have been taken
    logic optDrv;
    logic optRxLed;
    logic optTxLed;
    logic optPwr;
    logic optWake;
    assign optDrv = loaded && cfgReg_q[CFG_LINE_DRV];
    assign optRxLed = loaded && cfgReg_q[CFG_RX_LED];
    assign optTxLed = loaded && cfgReg_q[CFG_TX_LED];
    assign optPwr = loaded && cfgReg_q[CFG_PWR_SAVE];
    assign optWake = loaded && cfgReg_q[CFG_REMOTE_WAKE];

    // ****************************************************************
    // pin multiplexer
    // ****************************************************************
    logic [A_W-1:0] aOut_q, aOut_d, aOe_q, aOe_d, aPu_q, aUse;
    logic [C_W-1:0] cOut_q, cOut_d, cOe_q, cOe_d, cPu_q, cUse;
    logic [C_W-1:0] cPd_q, cPd_d;
    logic [A_W-1:0] dataIn_q, dataIn_d;
    logic [GP_W-1:0] gpIn_q, gpIn_d;
    logic [7:0] ctlIn_q, ctlIn_d;
    logic pwrUse;

    // ctlIn packs the function inputs of the active mode; idle is high
    always_comb begin
        aOut_d = '0;
        aOe_d = '0;
        aUse = '0;
        cOut_d = '0;
        cOe_d = '0;
        cUse = '0;
        cPd_d = '0;
        dataIn_d = '0;
        gpIn_d = '0;
        ctlIn_d = 8'hFF;
        cOut_d[9:8] = gpOut[13:12];
        cOe_d[9:8] = gpOe[13:12];
        gpIn_d[13:12] = pc[9:8];
        case (mode)
            MODE_SYNC_FIFO, MODE_ASYNC_FIFO, MODE_ASYNC_BB, MODE_SYNC_BB,
            MODE_CPU_FIFO, MODE_HALF_DUPLEX: begin
                aOut_d = dataOut;
                aOe_d = {A_W{dataOe}};
                aUse = '1;
                dataIn_d = pa;
            end
            default: begin
            end
        endcase
        case (mode)
            MODE_SYNC_FIFO, MODE_ASYNC_FIFO: begin
                cOut_d[1:0] = {txSpaceN, rxAvailN};
                cOe_d[1:0] = 2'h3;
                cUse[4:0] = 5'h1F;
                ctlIn_d[2:0] = pc[4:2];
                if (mode == MODE_SYNC_FIFO) begin
                    cOut_d[5] = fifoClk;
                    cOe_d[5] = 1'b1;
                    cUse[6:5] = 2'h3;
                    ctlIn_d[3] = pc[6];
                    aOe_d = {A_W{dataOe && !pc[6]}};
                end
            end
            MODE_ASYNC_BB, MODE_SYNC_BB: begin
                cOut_d[2:1] = {bbRdN, bbWrN};
                cOe_d[2:1] = 2'h3;
                cUse[4] = 1'b1;
                cUse[2:1] = 2'h3;
                ctlIn_d[0] = pc[4];
            end
            MODE_ENGINE: begin
                aOut_d[3:0] = {serSel, 1'b0, serOut, serClk};
                aOe_d[3:0] = 4'hB;
                ctlIn_d[0] = pa[2];
                aOut_d[7:4] = gpOut[3:0];
                aOe_d[7:4] = gpOe[3:0];
                gpIn_d[3:0] = pa[7:4];
                aUse = '1;
                cOut_d[6:0] = gpOut[10:4];
                cOe_d[6:0] = gpOe[10:4];
                gpIn_d[10:4] = pc[6:0];
                cUse[6:0] = 7'h7F;
            end
            MODE_FAST_SER: begin
                aOut_d[3:2] = {fast_ser_clear, fsDataOut};
                aOe_d[3:2] = 2'h3;
                aUse[3:0] = 4'hF;
                ctlIn_d[1:0] = pa[1:0];
                cUse[4] = 1'b1;
                ctlIn_d[2] = pc[4];
            end
            MODE_CPU_FIFO: begin
                cUse[3:0] = 4'hF;
                ctlIn_d[3:0] = pc[3:0];
            end
            MODE_HALF_DUPLEX: begin
                cOut_d[2] = hdStatus;
                cOe_d[2] = 1'b1;
                cUse[2:0] = 3'h7;
                ctlIn_d[1:0] = pc[1:0];
            end
            default: begin
                aOut_d = {3'h0, uartDtrN, 1'b0, uartRtsN, 1'b0, uartTx};
                aOe_d = UART_A_DRIVE;
                aUse = '1;
                ctlIn_d[4:0] = {pa[7:5], pa[3], pa[1]};
                cOut_d[4:3] = {txLedN, rxLedN};
                cOut_d[0] = lineDrvEn;
                cOe_d[0] = optDrv;
                cOe_d[3] = optRxLed;
                cOe_d[4] = optTxLed;
                cUse[0] = optDrv;
                cUse[4:3] = {optTxLed, optRxLed};
            end
        endcase
        pwrUse = (mode != MODE_ENGINE) || optPwr;
        cUse[PC_PWR_SAVE] = 1'b1;
        if (!pwrUse) begin
            cOut_d[PC_PWR_SAVE] = gpOut[11];
            cOe_d[PC_PWR_SAVE] = gpOe[11];
            cPd_d[PC_PWR_SAVE] = !gpOe[11];
            gpIn_d[11] = pc[PC_PWR_SAVE];
        end
        cUse[9:8] = gpOe[13:12];
    end

    // ****************************************************************
    // suspend and resume
    // ****************************************************************
    logic suspend_d;
    logic resume_d;
    logic cpuArm_q;
    logic cpuArm_d;
    logic [1:0] cPrev_q;
    logic cpuWake;

    // the cpu wake needs both falling edges with address held high
    always_comb begin
        suspend_d = pwrUse && !pc[PC_PWR_SAVE];
        cpuArm_d = cpuArm_q;
        if (cPrev_q[0] && !pc[0] && pc[1]) begin
            cpuArm_d = 1'b1;
        end else if (pc[0] || !pc[1]) begin
            cpuArm_d = 1'b0;
        end
        cpuWake = (mode == MODE_CPU_FIFO) && cpuArm_q && pc[1]
            && cPrev_q[1] && !pc[3];
        resume_d = suspend_q && (cpuWake
            || (mode == MODE_UART && optWake && !pa[7]));
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            aOut_q <= '0;
            aOe_q <= '0;
            aPu_q <= '1;
            cOut_q <= '0;
            cOe_q <= '0;
            cPu_q <= '1;
            cPd_q <= '0;
            dataIn_q <= '0;
            gpIn_q <= '0;
            ctlIn_q <= 8'hFF;
            suspend_q <= 1'b0;
            resume_q <= 1'b0;
            cpuArm_q <= 1'b0;
            cPrev_q <= 2'h3;
        end else begin
            aOut_q <= aOut_d;
            aOe_q <= aOe_d;
            aPu_q <= ~aUse;
            cOut_q <= cOut_d;
            cOe_q <= cOe_d;
            cPu_q <= ~cUse & ~cPd_d;
            cPd_q <= cPd_d;
            dataIn_q <= dataIn_d;
            gpIn_q <= gpIn_d;
            ctlIn_q <= ctlIn_d;
            suspend_q <= suspend_d;
            resume_q <= resume_d;
            cpuArm_q <= cpuArm_d;
            cPrev_q <= {pc[3], pc[0]};
        end
    end

    assign portAOut = aOut_q;
    assign portAOe = aOe_q;
    assign portAPullUp = aPu_q;
    assign portCOut = cOut_q;
    assign portCOe = cOe_q;
    assign portCPullUp = cPu_q;
    assign portCPullDown = cPd_q;
    assign regRdata = rdata_q;
    assign dataIn = dataIn_q;
    assign gpIn = gpIn_q;
    assign ctlIn = ctlIn_q;
    assign suspend = suspend_q;
    assign resumeReq = resume_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_uart_tx: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_UART) |=> aOe_q[0] && !aOe_q[1]
        && (aOut_q[0] == $past(uartTx)) && (aOut_q[2] == $past(uartRtsN)))
        else $error("uart port a mapping wrong");
    a_uart_led_off: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_UART && !optRxLed) |=> !cOe_q[3] && cPu_q[3])
        else $error("rx led driven while not configured");
    a_sync_clk: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_SYNC_FIFO)
        |=> cOe_q[5] && (cOut_q[5] == $past(fifoClk)) && !cOe_q[6])
        else $error("fifo clock not on c5");
    a_async_gen: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_ASYNC_FIFO) |=> (cOe_q[6:5] == 2'h0)
        && (cPu_q[6:5] == 2'h3) && (cOut_q[0] == $past(rxAvailN)))
        else $error("async fifo c5 c6 not general");
    a_bb_pulse: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_ASYNC_BB || mode == MODE_SYNC_BB)
        |=> (cOut_q[2:1] == $past({bbRdN, bbWrN})) && !cOe_q[4])
        else $error("bit-bang pulses misplaced");
    a_engine_map: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_ENGINE) |=> (aOe_q[3:0] == 4'hB)
        && (aOut_q[3] == $past(serSel)) && (ctlIn_q[0] == $past(pa[2])))
        else $error("engine serial lines misplaced");
    a_engine_gp: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_ENGINE) |=> (aOe_q[7:4] == $past(gpOe[3:0]))
        && (cOut_q[6:0] == $past(gpOut[10:4])))
        else $error("engine general lines misplaced");
    a_fast_pull: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_FAST_SER) |=> (aPu_q[7:4] == 4'hF)
        && (aOe_q == 8'h0C))
        else $error("fast serial upper lines not pulled inputs");
    a_cpu_inputs: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_CPU_FIFO) |=> (cOe_q[3:0] == 4'h0)
        && (ctlIn_q[3:0] == $past(pc[3:0])))
        else $error("cpu control lines not inputs");
    a_hd_status: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_HALF_DUPLEX) |=> (cOe_q[2:0] == 3'h4)
        && (cOut_q[2] == $past(hdStatus)))
        else $error("half duplex status misplaced");
    a_c7_input: assert property (@(posedge clk) disable iff (!resetn)
        (mode != MODE_ENGINE) |=> !cOe_q[7] && !cPd_q[7])
        else $error("power save line driven");
    a_c89_general: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> (cOe_q[9:8] == $past(gpOe[13:12])))
        else $error("c8 c9 not general lines");
    a_engine_pd: assert property (@(posedge clk) disable iff (!resetn)
        (mode == MODE_ENGINE && !optPwr && !gpOe[11])
        |=> cPd_q[7] && !cPu_q[7])
        else $error("engine c7 pull-down missing");
    a_suspend: assert property (@(posedge clk) disable iff (!resetn)
        (pwrUse && !pc[PC_PWR_SAVE]) [*2] |=> suspend_q)
        else $error("suspend not held while power save low");
    a_resume: assert property (@(posedge clk) disable iff (!resetn)
        (suspend_q && mode == MODE_UART && optWake && !pa[7]) |=> resume_q)
        else $error("ring indicate resume missed");

endmodule : bpm_pin_mux

// ===== bench/bpm_far_model.sv
// ****************************************************************
// far-side logic on one port, resolves each pin level
// ****************************************************************
module bpm_far_model #(
    parameter int W = 8
) (
    input logic clk,
    input logic [W-1:0] devOut,
    input logic [W-1:0] devOe,
    input logic [W-1:0] pullUp,
    input logic [W-1:0] pullDown,
    input logic [W-1:0] farVal,
    input logic [W-1:0] farEn,
    output logic [W-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // a floating line must not look stable, so it toggles each cycle
    logic floatQ = 1'b0;
    always @(posedge clk) floatQ <= ~floatQ;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            // yields to the device so boot outputs never see contention
            if (devOe[i]) pin[i] = devOut[i];
            else if (farEn[i]) pin[i] = farVal[i];
            else if (pullUp[i]) pin[i] = 1'b1;
            else if (pullDown[i]) pin[i] = 1'b0;
            else pin[i] = floatQ;
        end
    end
endmodule : bpm_far_model

// ===== bench/bpm_pin_mux_tb.sv
// ****************************************************************
// self-checking bench for the pin multiplexer
// ****************************************************************
module bpm_pin_mux_tb import bpm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, cfgMemPresent = 1'b1;
    logic regWr = 1'b0, regRd = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0, regRdata, rdv;
    logic [A_W-1:0] portAIn, portAOut, portAOe, portAPullUp, dataOut, dataIn;
    logic [C_W-1:0] portCIn, portCOut, portCOe, portCPullUp, portCPullDown;
    logic [GP_W-1:0] gpOut, gpOe, gpIn;
    logic [7:0] ctlIn, farA = '1;
    logic [C_W-1:0] farC = '1;
    logic uartTx, uartRtsN, uartDtrN, lineDrvEn, rxLedN, txLedN, dataOe;
    logic rxAvailN, txSpaceN, fifoClk, bbWrN, bbRdN, serClk, serOut, serSel;
    logic fsDataOut, fast_ser_clear, hdStatus, suspend, resumeReq;
    logic [63:0] rnd;
    logic hit;
    int seed = 32'haba6c07f, err_total = 0, comparisons = 0, cyc = 0;

    bpm_pin_mux uut (.*);
    bpm_far_model #(.W(A_W)) farAm (.clk, .devOut(portAOut),
        .devOe(portAOe), .pullUp(portAPullUp), .pullDown(8'h00),
        .farVal(farA), .farEn(8'hFF), .pin(portAIn));
    bpm_far_model #(.W(C_W)) farCm (.clk, .devOut(portCOut),
        .devOe(portCOe), .pullUp(portCPullUp), .pullDown(portCPullDown),
        .farVal(farC), .farEn(10'h3FF), .pin(portCIn));

    always #5 clk = ~clk;
    // whole run is a few hundred cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic stir();
        rnd = {$random(seed), $random(seed)};
        {uartTx, uartRtsN, uartDtrN, lineDrvEn, rxLedN, txLedN, dataOe,
         rxAvailN, txSpaceN, fifoClk, bbWrN, bbRdN, serClk, serOut, serSel,
         fsDataOut, fast_ser_clear, hdStatus, dataOut, gpOut, gpOe, farA}
            <= rnd[61:0];
    endtask : stir

    // pin inputs pass a synchroniser, so allow well over five cycles
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask : settle

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rdv = regRdata;
    endtask : rd

    task automatic load(input logic [3:0] m);
        wr(OFS_CONFIG, {28'h0, m});
        wr(OFS_LOAD, 32'h0);
    endtask : load

    function automatic logic [7:0] expAOe(input logic [3:0] m);
        case (m)
            4'h0: return UART_A_DRIVE;
            4'h5: return {gpOe[3:0], 4'hB};
            4'h6: return 8'h0C;
            default: return 8'h04;
        endcase
    endfunction : expAOe

    function automatic logic [6:0] expCOe(input logic [3:0] m);
        case (m)
            4'h1: return 7'h23;
            4'h2: return 7'h03;
            4'h3, 4'h4: return 7'h06;
            4'h5: return gpOe[10:4];
            4'h8: return 7'h04;
            default: return 7'h00;
        endcase
    endfunction : expCOe

    initial begin
        stir();
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        wr(OFS_CONFIG, 32'h5);
        stir();
        settle();
        chk(portAOe, expAOe(4'h0));
        chk({portAOut[4], portAOut[2], portAOut[0]},
            {uartDtrN, uartRtsN, uartTx});
        chk(ctlIn[4:0], {farA[7:5], farA[3], farA[1]});
        rd(OFS_STATUS);
        chk(rdv & 32'h9F, 32'h80);
        rd(OFS_CONFIG);
        chk(rdv[8:0], 9'h005);
        rd(4'hC);
        chk(rdv, 32'h0);
        rd(OFS_LOAD);
        chk(rdv, 32'h0);
        $display("test boot done");
        wr(OFS_LOAD, 32'h0);
        rd(OFS_STATUS);
        chk(rdv & 32'h9F, 32'h95);
        repeat (6) begin
            stir();
            farC <= 10'($random(seed));
            settle();
            chk(portAOe, expAOe(4'h5));
            chk({portAOut[3], portAOut[1:0]}, {serSel, serOut, serClk});
            chk(ctlIn[0], farA[2]);
            chk(portAOut[7:4] & gpOe[3:0], gpOut[3:0] & gpOe[3:0]);
            chk(portCOe, {gpOe[13:12], gpOe[11:4]});
            chk(gpIn, (gpOut & gpOe) | ({farC, farA[7:4]} & ~gpOe));
            chk(suspend, 1'b0);
            if (!gpOe[11]) chk(portCPullDown[7], 1'b1);
        end
        $display("test engine done");
        for (int m = 1; m < 9; m++) begin
            load(4'(m));
            stir();
            settle();
            chk(portCOe[6:0], expCOe(4'(m)));
        end
        $display("test mode sweep done");
        load(4'h6);
        farC <= 10'h37F;
        stir();
        settle();
        chk(portAOe, expAOe(4'h6));
        chk(portAPullUp[7:4], 4'hF);
        chk(portAOut[3:2], {fast_ser_clear, fsDataOut});
        chk(ctlIn[2:0], {farC[4], farA[1:0]});
        chk(suspend, 1'b1);
        farC <= '1;
        settle();
        chk(suspend, 1'b0);
        $display("test fast serial done");
        load(4'h7);
        farC <= 10'h37F;
        settle();
        chk(suspend, 1'b1);
        chk(portCOe[3:0], 4'h0);
        chk(ctlIn[3:0], 4'hF);
        chk(resumeReq, 1'b0);
        farC[0] <= 1'b0;
        settle();
        farC[3] <= 1'b0;
        hit = 1'b0;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (resumeReq) hit = 1'b1;
        end
        chk(hit, 1'b1);
        $display("test cpu wake done");
        test_done();
    end
endmodule : bpm_pin_mux_tb
